// File: core/hps_defines.svh
// shared constants of the host port: pin positions, frame layout, timing, host register map
// assumes nothing; included by the package, the interface and both ends
`ifndef HPS_DEFINES_SVH
`define HPS_DEFINES_SVH
`define HPS_AW 13
`define HPS_DW 8
`define HPS_D_CPOL 7
`define HPS_D_CPHA 6
`define HPS_D_MSB 5
`define HPS_D_SCLK 2
`define HPS_D_MOSI 1
`define HPS_D_MISO 0
`define HPS_HDR_RW 0
`define HPS_HDR_ADDR 2
`define HPS_HDR_BITS 16
`define HPS_FRAME_BITS 24
`define HPS_OE_ALL 8'h00
`define HPS_OE_NONE 8'hFF
`define HPS_MISO_OE_N 8'hFE
`define HPS_HOST_SER_OE_N 8'h19
`define HPS_SYNC_IDLE {3'h7, 22'h000000}
`define HPS_MCLK_NS 20
`define HPS_SCLK_HALF_NS 80
`define HPS_SCLK_HALF_CYC (`HPS_SCLK_HALF_NS / `HPS_MCLK_NS)
`define HPS_STB_NS 160
`define HPS_STB_CYC ((`HPS_STB_NS + `HPS_MCLK_NS - 1) / `HPS_MCLK_NS)
`define HPS_SW_AW 5
`define HPS_SW_DW 16
`define HPS_OFF_CTRL 5'h00
`define HPS_OFF_ADDR 5'h04
`define HPS_OFF_WDATA 5'h08
`define HPS_OFF_STAT 5'h0C
`define HPS_OFF_RDATA 5'h10
`define HPS_CTRL_GO 0
`define HPS_CTRL_RW 1
`define HPS_CTRL_SER 2
`define HPS_CTRL_CPOL 3
`define HPS_CTRL_CPHA 4
`define HPS_CTRL_MSB 5
`endif

// File: core/hps_pkg.sv
// types shared by the host port ends
// assumes hps_defines.svh on the include path
`include "hps_defines.svh"
package hps_pkg;
	typedef logic [`HPS_AW-1:0] hps_addr_t;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_PSTB  = 3'b001,
		H_PHOLD = 3'b010,
		H_SLEAD = 3'b011,
		H_SCLK  = 3'b100,
		H_STAIL = 3'b101
	} hps_hstate_t;
endpackage

// File: core/hps_if.sv
// pins between the register host and the device port
// assumes undriven data pins read low, as the straps default low
`timescale 1ns/1ps
`default_nettype none
`include "hps_defines.svh"
interface hps_if;
	logic                 host_select_n;
	logic                 write_strobe_n;
	logic                 read_strobe_n;
	logic                 serial_select;
	logic [`HPS_AW-1:0]   reg_addr;
	logic [`HPS_DW-1:0]   host_dout;
	logic [`HPS_DW-1:0]   host_oe_n;
	logic [`HPS_DW-1:0]   dev_dout;
	logic [`HPS_DW-1:0]   dev_oe_n;
	logic [`HPS_DW-1:0]   d;

	always_comb begin
		for (int i = 0; i < `HPS_DW; i++) begin
			if (!dev_oe_n[i]) begin
				d[i] = dev_dout[i];
			end else if (!host_oe_n[i]) begin
				d[i] = host_dout[i];
			end else begin
				d[i] = 1'b0;
			end
		end
	end

	modport dev (input host_select_n, write_strobe_n, read_strobe_n, serial_select, reg_addr, d,
		output dev_dout, dev_oe_n);
	modport host (output host_select_n, write_strobe_n, read_strobe_n, serial_select, reg_addr,
		host_dout, host_oe_n, input d);
endinterface
`default_nettype wire

// File: core/hps_dev_end.sv
// device end of the host port: register file reached by parallel strobes or serial frames
// assumes every pin is asynchronous to mclk and the serial clock is far slower than mclk
`timescale 1ns/1ps
`default_nettype none
`include "hps_defines.svh"
module hps_dev_end import hps_pkg::*; #(
	parameter int REG_AW = 4
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	hps_if.dev                     bus,
	input  wire logic [REG_AW-1:0] user_idx,
	output logic      [`HPS_DW-1:0] user_rdata,
	output logic                   wr_evt,
	output logic                   serial_mode,
	output logic                   frame_active
);
	localparam int SW = 4 + `HPS_AW + `HPS_DW;
	localparam int NREG = 2 ** REG_AW;

	logic [SW-1:0]         sync1_reg;
	logic [SW-1:0]         sync2_reg;
	logic                  sel_n_s;
	logic                  wr_n_s;
	logic                  rd_n_s;
	logic                  ser_s;
	hps_addr_t             addr_s;
	logic [`HPS_DW-1:0]    d_s;
	logic                  wr_n_d_reg;
	logic                  sel_n_d_reg;
	logic                  sclk_d_reg;
	logic                  cpol_reg;
	logic                  cpha_reg;
	logic                  msb_reg;
	logic [4:0]            cnt_reg;
	logic [`HPS_FRAME_BITS-1:0] rx_reg;
	logic                  miso_reg;
	logic [`HPS_DW-1:0]    rd_ord_reg;
	logic                  ser_wr_pend_reg;
	logic [`HPS_DW-1:0]    dout_reg;
	logic [`HPS_DW-1:0]    oe_n_reg;
	logic                  wr_evt_reg;
	logic [`HPS_DW-1:0]    user_rdata_reg;
	logic [`HPS_DW-1:0]    regs [NREG];
	logic                  par_wr;
	logic                  par_rd;
	logic                  frame_act;
	logic                  frame_start;
	logic                  sclk_s;
	logic                  samp;
	logic                  ser_rd_load;
	logic                  ser_rd_shift;
	logic                  ser_wr_last;
	logic                  par_map;
	logic                  ser_map;
	hps_addr_t             ser_addr;
	logic [`HPS_DW-1:0]    ser_wdata;
	logic [`HPS_DW-1:0]    par_rval;
	logic [`HPS_DW-1:0]    ser_rval;
	logic [`HPS_DW-1:0]    rd_ord;

	// every pin, the shared data bus included, is resynchronised as one group
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_reg <= `HPS_SYNC_IDLE;
			sync2_reg <= `HPS_SYNC_IDLE;
		end else begin
			sync1_reg <= {bus.host_select_n, bus.write_strobe_n, bus.read_strobe_n,
				bus.serial_select, bus.reg_addr, bus.d};
			sync2_reg <= sync1_reg;
		end
	end
	assign {sel_n_s, wr_n_s, rd_n_s, ser_s, addr_s, d_s} = sync2_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_n_d_reg <= 1'b1;
			sel_n_d_reg <= 1'b1;
			sclk_d_reg <= 1'b0;
		end else begin
			wr_n_d_reg <= wr_n_s;
			sel_n_d_reg <= sel_n_s;
			sclk_d_reg <= sclk_s;
		end
	end

	assign par_wr = !ser_s && !sel_n_s && wr_n_s && !wr_n_d_reg;
	assign par_rd = !ser_s && !sel_n_s && !rd_n_s;
	assign frame_act = ser_s && !sel_n_s;
	assign frame_start = frame_act && sel_n_d_reg;
	assign sclk_s = d_s[`HPS_D_SCLK];

	// straps are frozen per frame so a mid-frame wiggle cannot split a word
	always_ff @(posedge mclk) begin
		if (rst) begin
			cpol_reg <= 1'b0;
			cpha_reg <= 1'b0;
			msb_reg <= 1'b0;
		end else if (frame_start) begin
			cpol_reg <= d_s[`HPS_D_CPOL];
			cpha_reg <= d_s[`HPS_D_CPHA];
			msb_reg <= d_s[`HPS_D_MSB];
		end
	end

	// sampling edge is the leading edge for phase 0, the trailing edge for phase 1
	assign samp = frame_act && !frame_start && (sclk_s != sclk_d_reg) &&
		(sclk_s == !(cpol_reg ^ cpha_reg)) && (cnt_reg < 5'(`HPS_FRAME_BITS));

	always_ff @(posedge mclk) begin
		if (rst || !frame_act) begin
			cnt_reg <= 5'h00;
		end else if (samp) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_reg <= '0;
		end else if (samp) begin
			rx_reg[cnt_reg] <= d_s[`HPS_D_MOSI];
		end
	end

	// flag bits sit at fixed slots; only address and data follow the order strap
	for (genvar k = 0; k < `HPS_AW; k++) begin : g_addr
		assign ser_addr[k] = msb_reg ? rx_reg[`HPS_HDR_ADDR + `HPS_AW - 1 - k]
			: rx_reg[`HPS_HDR_ADDR + k];
	end
	for (genvar k = 0; k < `HPS_DW; k++) begin : g_data
		assign ser_wdata[k] = msb_reg ? rx_reg[`HPS_FRAME_BITS - 1 - k]
			: rx_reg[`HPS_HDR_BITS + k];
		assign rd_ord[k] = msb_reg ? ser_rval[`HPS_DW - 1 - k] : ser_rval[k];
	end

	assign par_map = (addr_s[`HPS_AW-1:REG_AW] == '0);
	assign ser_map = (ser_addr[`HPS_AW-1:REG_AW] == '0);
	assign par_rval = par_map ? regs[addr_s[REG_AW-1:0]] : '0;
	assign ser_rval = ser_map ? regs[ser_addr[REG_AW-1:0]] : '0;

	assign ser_rd_load = samp && (cnt_reg == 5'(`HPS_HDR_BITS - 1)) && rx_reg[`HPS_HDR_RW];
	assign ser_rd_shift = samp && (cnt_reg >= 5'(`HPS_HDR_BITS)) && rx_reg[`HPS_HDR_RW];
	assign ser_wr_last = samp && (cnt_reg == 5'(`HPS_FRAME_BITS - 1)) && !rx_reg[`HPS_HDR_RW];

	// next read bit follows each sampling edge after a resync delay, which is the hold
	always_ff @(posedge mclk) begin
		if (rst) begin
			miso_reg <= 1'b0;
			rd_ord_reg <= '0;
		end else if (ser_rd_load) begin
			rd_ord_reg <= rd_ord;
			miso_reg <= rd_ord[0];
		end else if (ser_rd_shift) begin
			miso_reg <= rd_ord_reg[cnt_reg[2:0] + 3'h1];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ser_wr_pend_reg <= 1'b0;
		end else begin
			ser_wr_pend_reg <= ser_wr_last;
		end
	end

	// unmapped addresses ignore writes and read as zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NREG; i++) begin
				regs[i] <= '0;
			end
		end else if (par_wr && par_map) begin
			regs[addr_s[REG_AW-1:0]] <= d_s;
		end else if (ser_wr_pend_reg && ser_map) begin
			regs[ser_addr[REG_AW-1:0]] <= ser_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			oe_n_reg <= `HPS_OE_NONE;
			dout_reg <= '0;
		end else begin
			oe_n_reg <= par_rd ? `HPS_OE_ALL : frame_act ? `HPS_MISO_OE_N : `HPS_OE_NONE;
			dout_reg <= par_rd ? par_rval : (`HPS_DW)'(miso_reg);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_evt_reg <= 1'b0;
			user_rdata_reg <= '0;
		end else begin
			wr_evt_reg <= (par_wr && par_map) || (ser_wr_pend_reg && ser_map);
			user_rdata_reg <= regs[user_idx];
		end
	end

	assign bus.dev_dout = dout_reg;
	assign bus.dev_oe_n = oe_n_reg;
	assign user_rdata = user_rdata_reg;
	assign wr_evt = wr_evt_reg;
	assign serial_mode = ser_s;
	assign frame_active = frame_act;
endmodule
`default_nettype wire

// File: core/hps_host_end.sv
// host end: runs one parallel or serial register access per software order
// assumes the device resynchronises pins, so strobes and clock phases last several mclk
`timescale 1ns/1ps
`default_nettype none
`include "hps_defines.svh"
module hps_host_end import hps_pkg::*; (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	hps_if.host                        bus,
	input  wire logic [`HPS_SW_AW-1:0] sw_addr,
	input  wire logic [`HPS_SW_DW-1:0] sw_wdata,
	input  wire logic                  sw_wr,
	input  wire logic                  sw_rd,
	output logic      [`HPS_SW_DW-1:0] sw_rdata
);
	localparam logic [7:0] HALF = 8'(`HPS_SCLK_HALF_CYC);
	localparam logic [7:0] STB = 8'(`HPS_STB_CYC);
	localparam logic [5:0] LAST_EDGE = 6'(2 * `HPS_FRAME_BITS - 1);

	hps_hstate_t           st_reg;
	logic [`HPS_CTRL_MSB:`HPS_CTRL_RW] ctrl_reg;
	hps_addr_t             addr_reg;
	logic [`HPS_DW-1:0]    wdata_reg;
	logic [`HPS_DW-1:0]    rdata_reg;
	logic                  done_reg;
	logic [7:0]            tmr_reg;
	logic [5:0]            ec_reg;
	logic                  sel_n_reg;
	logic                  wr_n_reg;
	logic                  rd_n_reg;
	logic                  sclk_reg;
	logic                  mosi_reg;
	logic [`HPS_DW-1:0]    rx_reg;
	logic [`HPS_DW-1:0]    d1_reg;
	logic [`HPS_DW-1:0]    d2_reg;
	logic [`HPS_SW_DW-1:0] sw_rdata_reg;
	logic [`HPS_FRAME_BITS-1:0] tx;
	logic [`HPS_DW-1:0]    rx_ord;
	logic [`HPS_DW-1:0]    strap_word;
	logic [4:0]            bitn;
	logic                  idle;
	logic                  go;

	assign idle = (st_reg == H_IDLE);
	assign go = sw_wr && idle && (sw_addr == `HPS_OFF_CTRL) && sw_wdata[`HPS_CTRL_GO];
	assign bitn = ec_reg[5:1];

	always_ff @(posedge mclk) begin
		if (rst) begin
			d1_reg <= '0;
			d2_reg <= '0;
		end else begin
			d1_reg <= bus.d;
			d2_reg <= d1_reg;
		end
	end

	// settings are frozen while busy, so the straps stay put during a frame
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
		end else if (sw_wr && idle) begin
			case (sw_addr)
			`HPS_OFF_CTRL: ctrl_reg <= sw_wdata[`HPS_CTRL_MSB:`HPS_CTRL_RW];
			`HPS_OFF_ADDR: addr_reg <= sw_wdata[`HPS_AW-1:0];
			`HPS_OFF_WDATA: wdata_reg <= sw_wdata[`HPS_DW-1:0];
			default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sw_rdata_reg <= '0;
		end else if (sw_rd) begin
			case (sw_addr)
			`HPS_OFF_CTRL: sw_rdata_reg <= (`HPS_SW_DW)'({ctrl_reg, 1'b0});
			`HPS_OFF_ADDR: sw_rdata_reg <= (`HPS_SW_DW)'(addr_reg);
			`HPS_OFF_WDATA: sw_rdata_reg <= (`HPS_SW_DW)'(wdata_reg);
			`HPS_OFF_STAT: sw_rdata_reg <= (`HPS_SW_DW)'({done_reg, !idle});
			`HPS_OFF_RDATA: sw_rdata_reg <= (`HPS_SW_DW)'(rdata_reg);
			default: sw_rdata_reg <= '0;
			endcase
		end else begin
			sw_rdata_reg <= '0;
		end
	end

	// frame: read/write flag, fixed flag, address, spare, data
	always_comb begin
		tx = '0;
		tx[`HPS_HDR_RW] = ctrl_reg[`HPS_CTRL_RW];
		for (int k = 0; k < `HPS_AW; k++) begin
			tx[`HPS_HDR_ADDR + k] = ctrl_reg[`HPS_CTRL_MSB] ? addr_reg[`HPS_AW - 1 - k] : addr_reg[k];
		end
		for (int k = 0; k < `HPS_DW; k++) begin
			tx[`HPS_HDR_BITS + k] = ctrl_reg[`HPS_CTRL_MSB] ? wdata_reg[`HPS_DW - 1 - k] : wdata_reg[k];
		end
	end
	for (genvar k = 0; k < `HPS_DW; k++) begin : g_rx
		assign rx_ord[k] = ctrl_reg[`HPS_CTRL_MSB] ? rx_reg[`HPS_DW - 1 - k] : rx_reg[k];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= H_IDLE;
			tmr_reg <= '0;
			ec_reg <= '0;
			sel_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			sclk_reg <= 1'b0;
			mosi_reg <= 1'b0;
			rx_reg <= '0;
			rdata_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			case (st_reg)
			H_IDLE: begin
				ec_reg <= '0;
				if (go) begin
					done_reg <= 1'b0;
					sel_n_reg <= 1'b0;
					if (sw_wdata[`HPS_CTRL_SER]) begin
						mosi_reg <= sw_wdata[`HPS_CTRL_RW];
						sclk_reg <= sw_wdata[`HPS_CTRL_CPOL];
						tmr_reg <= HALF - 8'h01;
						st_reg <= H_SLEAD;
					end else begin
						wr_n_reg <= sw_wdata[`HPS_CTRL_RW];
						rd_n_reg <= !sw_wdata[`HPS_CTRL_RW];
						tmr_reg <= STB - 8'h01;
						st_reg <= H_PSTB;
					end
				end else begin
					sclk_reg <= ctrl_reg[`HPS_CTRL_CPOL];
				end
			end
			H_PSTB: begin
				if (tmr_reg == 8'h00) begin
					if (!rd_n_reg) begin
						rdata_reg <= d2_reg;
					end
					wr_n_reg <= 1'b1;
					rd_n_reg <= 1'b1;
					tmr_reg <= STB - 8'h01;
					st_reg <= H_PHOLD;
				end else begin
					tmr_reg <= tmr_reg - 8'h01;
				end
			end
			H_PHOLD: begin
				if (tmr_reg == 8'h00) begin
					sel_n_reg <= 1'b1;
					done_reg <= 1'b1;
					st_reg <= H_IDLE;
				end else begin
					tmr_reg <= tmr_reg - 8'h01;
				end
			end
			H_SLEAD: begin
				if (tmr_reg == 8'h00) begin
					st_reg <= H_SCLK;
				end else begin
					tmr_reg <= tmr_reg - 8'h01;
				end
			end
			H_SCLK: begin
				if (tmr_reg == 8'h00) begin
					tmr_reg <= HALF - 8'h01;
					sclk_reg <= !sclk_reg;
					ec_reg <= ec_reg + 6'h01;
					if (ec_reg[0] == ctrl_reg[`HPS_CTRL_CPHA]) begin
						if (bitn >= 5'(`HPS_HDR_BITS)) begin
							rx_reg[bitn[2:0]] <= d2_reg[`HPS_D_MISO];
						end
					end else if (ctrl_reg[`HPS_CTRL_CPHA]) begin
						mosi_reg <= tx[bitn];
					end else if (bitn < 5'(`HPS_FRAME_BITS - 1)) begin
						mosi_reg <= tx[bitn + 5'h01];
					end
					if (ec_reg == LAST_EDGE) begin
						st_reg <= H_STAIL;
					end
				end else begin
					tmr_reg <= tmr_reg - 8'h01;
				end
			end
			H_STAIL: begin
				if (tmr_reg == 8'h00) begin
					sel_n_reg <= 1'b1;
					done_reg <= 1'b1;
					if (ctrl_reg[`HPS_CTRL_RW]) begin
						rdata_reg <= rx_ord;
					end
					st_reg <= H_IDLE;
				end else begin
					tmr_reg <= tmr_reg - 8'h01;
				end
			end
			default: st_reg <= H_IDLE;
			endcase
		end
	end

	always_comb begin
		strap_word = '0;
		strap_word[`HPS_D_CPOL] = ctrl_reg[`HPS_CTRL_CPOL];
		strap_word[`HPS_D_CPHA] = ctrl_reg[`HPS_CTRL_CPHA];
		strap_word[`HPS_D_MSB] = ctrl_reg[`HPS_CTRL_MSB];
		strap_word[`HPS_D_SCLK] = sclk_reg;
		strap_word[`HPS_D_MOSI] = mosi_reg;
	end

	assign bus.host_select_n = sel_n_reg;
	assign bus.write_strobe_n = wr_n_reg;
	assign bus.read_strobe_n = rd_n_reg;
	assign bus.serial_select = ctrl_reg[`HPS_CTRL_SER];
	assign bus.reg_addr = addr_reg;
	assign bus.host_dout = ctrl_reg[`HPS_CTRL_SER] ? strap_word : wdata_reg;
	assign bus.host_oe_n = ctrl_reg[`HPS_CTRL_SER] ? `HPS_HOST_SER_OE_N
		: (!sel_n_reg && !ctrl_reg[`HPS_CTRL_RW]) ? `HPS_OE_ALL : `HPS_OE_NONE;
	assign sw_rdata = sw_rdata_reg;
endmodule
`default_nettype wire

// File: testbench/hps_link_asserts.sv
// assertions on the pins between the host end and the device end
// assumes instantiation beside the interface, fed with its signals by name
`timescale 1ns/1ps
`default_nettype none
`include "hps_defines.svh"
module hps_link_asserts (
	input wire logic               mclk,
	input wire logic               rst,
	input wire logic               host_select_n,
	input wire logic               write_strobe_n,
	input wire logic               read_strobe_n,
	input wire logic               serial_select,
	input wire logic [`HPS_AW-1:0] reg_addr,
	input wire logic [`HPS_DW-1:0] host_oe_n,
	input wire logic [`HPS_DW-1:0] dev_oe_n,
	input wire logic [`HPS_DW-1:0] d
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	property p_release;
		host_select_n [*6] |-> dev_oe_n == `HPS_OE_NONE;
	endproperty
	a_release: assert property (p_release) else $error("device drives while deselected");
	property p_no_fight;
		((~dev_oe_n) & (~host_oe_n)) == 8'h00;
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends drive one pin");
	property p_par_read;
		$fell(read_strobe_n) && !host_select_n && !serial_select |-> ##[2:5] dev_oe_n == `HPS_OE_ALL;
	endproperty
	a_par_read: assert property (p_par_read) else $error("parallel read not driven");
	property p_par_width;
		!serial_select && dev_oe_n != `HPS_OE_NONE |-> dev_oe_n == `HPS_OE_ALL;
	endproperty
	a_par_width: assert property (p_par_width) else $error("partial bus drive");
	property p_miso_only;
		serial_select && dev_oe_n != `HPS_OE_NONE |-> dev_oe_n == `HPS_MISO_OE_N;
	endproperty
	a_miso_only: assert property (p_miso_only) else $error("serial drive off data out");
	property p_host_pins;
		serial_select && !host_select_n |-> host_oe_n == `HPS_HOST_SER_OE_N;
	endproperty
	a_host_pins: assert property (p_host_pins) else $error("host serial pins wrong");
	property p_idle_pol;
		$fell(host_select_n) && serial_select |-> d[`HPS_D_SCLK] == d[`HPS_D_CPOL];
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("serial clock idle level");
	property p_straps_held;
		serial_select && !host_select_n && !$past(host_select_n) |-> $stable(d[7:5]);
	endproperty
	a_straps_held: assert property (p_straps_held) else $error("straps moved in frame");
	property p_addr_held;
		!host_select_n && !$past(host_select_n) |-> $stable(reg_addr);
	endproperty
	a_addr_held: assert property (p_addr_held) else $error("address moved");
	property p_wr_hold;
		$rose(write_strobe_n) && !host_select_n |-> !host_select_n [*4];
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("select dropped at strobe");
	property p_frame_len;
		$fell(host_select_n) && serial_select |-> ##[150:260] $rose(host_select_n);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("serial frame length");
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench: host end and device end joined by the pin interface
// assumes software orders reach the device only through the host registers
`timescale 1ns/1ps
`default_nettype none
`include "hps_defines.svh"
module tb;
	logic                  mclk = 1'b0;
	logic                  rst = 1'b1;
	logic [`HPS_SW_AW-1:0] sw_addr = '0;
	logic [`HPS_SW_DW-1:0] sw_wdata = '0;
	logic                  sw_wr = 1'b0;
	logic                  sw_rd = 1'b0;
	logic [`HPS_SW_DW-1:0] sw_rdata;
	logic [3:0]            user_idx = '0;
	logic [`HPS_DW-1:0]    user_rdata;
	logic                  wr_evt;
	logic                  serial_mode;
	logic                  frame_active;
	int                    err_count = 0;
	int                    num_checks = 0;
	int                    evt_n = 0;
	int                    mon_cnt = 0;
	logic [23:0]           mon_bits = '0;
	logic                  mon_prev = 1'b0;
	logic                  mon_on = 1'b0;
	wire  [`HPS_DW-1:0]    pins;

	hps_if i_hps_if ();
	assign pins = i_hps_if.d;
	hps_host_end i_hps_host_end (.mclk(mclk), .rst(rst), .bus(i_hps_if.host), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	hps_dev_end #(.REG_AW(4)) i_hps_dev_end (.mclk(mclk), .rst(rst), .bus(i_hps_if.dev),
		.user_idx(user_idx), .user_rdata(user_rdata), .wr_evt(wr_evt),
		.serial_mode(serial_mode), .frame_active(frame_active));
	hps_link_asserts i_hps_link_asserts (.mclk(mclk), .rst(rst),
		.host_select_n(i_hps_if.host_select_n), .write_strobe_n(i_hps_if.write_strobe_n),
		.read_strobe_n(i_hps_if.read_strobe_n), .serial_select(i_hps_if.serial_select),
		.reg_addr(i_hps_if.reg_addr), .host_oe_n(i_hps_if.host_oe_n),
		.dev_oe_n(i_hps_if.dev_oe_n), .d(i_hps_if.d));

	always #10 mclk = ~mclk;

	// wire monitor on the falling edge, clear of the design's own updates
	always @(negedge mclk) begin
		if (wr_evt === 1'b1) begin
			evt_n <= evt_n + 1;
		end
		mon_prev <= pins[`HPS_D_SCLK];
		mon_on <= !i_hps_if.host_select_n && i_hps_if.serial_select;
		if (!mon_on && !i_hps_if.host_select_n) begin
			mon_cnt <= 0;
		end else if (mon_on && pins[2] != mon_prev && ((pins[2] != pins[7]) != pins[6])
			&& mon_cnt < 24) begin
			mon_bits[mon_cnt] <= pins[`HPS_D_MOSI];
			mon_cnt <= mon_cnt + 1;
		end
	end

	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic sw_write(input logic [4:0] a, input logic [15:0] v);
		@(posedge mclk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
	endtask

	task automatic sw_read(input logic [4:0] a, output logic [15:0] v);
		@(posedge mclk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1;
		v = sw_rdata;
	endtask

	// m: bit0 polarity, bit1 phase, bit2 msb first; w is also the expected read data
	task automatic access(input logic ser, input logic rw, input logic [2:0] m,
		input logic [12:0] a, input logic [7:0] w);
		logic [15:0] s;
		logic [23:0] e;
		logic [23:0] g;
		int i;
		sw_write(`HPS_OFF_ADDR, {3'h0, a});
		sw_write(`HPS_OFF_WDATA, {8'h00, w});
		sw_write(`HPS_OFF_CTRL, {10'h000, m, ser, rw, 1'b1});
		if (ser) begin
			i = 0;
			while (i_hps_if.host_select_n !== 1'b0 && i < 20) begin
				@(posedge mclk);
				#1;
				i++;
			end
			g = {20'h0, pins[2], pins[5], pins[6], pins[7]};
			check("frame start pins", {20'h0, m[0], m}, g);
			// two resync stages after select falls, then the frame flag stands
			repeat (3) @(posedge mclk);
			#1;
			check("frame active", 24'h000001, {23'h0, frame_active});
		end
		for (i = 0; i < 200; i++) begin
			sw_read(`HPS_OFF_STAT, s);
			if (s[1:0] == 2'b10) break;
		end
		check("status", 24'h000002, {8'h00, s});
		if (ser) begin
			e = '0;
			e[0] = rw;
			for (i = 0; i < 13; i++) e[2+i] = m[2] ? a[12-i] : a[i];
			for (i = 0; i < 8; i++) e[16+i] = m[2] ? w[7-i] : w[i];
			g = mon_bits;
			// on reads the host still shifts its data byte, which the device ignores
			if (rw) begin
				e[23:16] = 8'h00;
				g[23:16] = 8'h00;
			end
			check("frame count", 24'h000018, 24'(mon_cnt));
			check("frame bits", e, g);
		end
		if (rw) begin
			sw_read(`HPS_OFF_RDATA, s);
			check("read data", {16'h0000, w}, {8'h00, s});
		end
	endtask

	task automatic dev_reg(input logic [3:0] idx, input logic [7:0] exp);
		@(posedge mclk);
		user_idx <= idx;
		repeat (2) @(posedge mclk);
		#1;
		check("device register", {16'h0000, exp}, {16'h0000, user_rdata});
	endtask

	task automatic t_parallel();
		int n;
		n = evt_n;
		access(1'b0, 1'b0, 3'h0, 13'h0003, 8'hA5);
		dev_reg(4'h3, 8'hA5);
		check("write events", 24'(n + 1), 24'(evt_n));
		check("serial mode", 24'h000000, {23'h0, serial_mode});
		check("frame active", 24'h000000, {23'h0, frame_active});
		access(1'b0, 1'b1, 3'h0, 13'h0003, 8'hA5);
	endtask

	// upper address bits set: must neither write nor read back
	task automatic t_unmapped();
		logic [15:0] s;
		int n;
		n = evt_n;
		access(1'b0, 1'b0, 3'h0, 13'h1003, 8'h5A);
		dev_reg(4'h3, 8'hA5);
		check("write events", 24'(n), 24'(evt_n));
		access(1'b0, 1'b1, 3'h0, 13'h1003, 8'h00);
		sw_read(5'h14, s);
		check("unmapped offset", 24'h000000, {8'h00, s});
	endtask

	task automatic t_serial();
		logic [3:0]  k;
		logic [12:0] a;
		logic [7:0]  v;
		for (int j = 0; j < 8; j++) begin
			k = 4'(j);
			a = {9'h000, 1'b1, k[2:0]};
			v = 8'hC1 + {5'h00, k[2:0]};
			access(1'b1, 1'b0, k[2:0], a, v);
			dev_reg({1'b1, k[2:0]}, v);
			check("serial mode", 24'h000001, {23'h0, serial_mode});
			access(1'b1, 1'b1, k[2:0], a, v);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_parallel();
		t_unmapped();
		t_serial();
		t_parallel();
		give_verdict();
	end

	// about eleven times the expected run
	initial begin
		#(`HPS_MCLK_NS * 40000);
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
